// ### hw/mrs_sequencer.sv
module mrs_sequencer #(
  parameter int unsigned P5_HALF_RAMPS = mrs_pkg::P5_HALF_RAMPS
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Controller side
  input wire logic start_i,
  output logic busy_o,
  output logic done_o,
  output mrs_pkg::mrs_result_s result_o,
  // Hybrid side
  input wire logic integrator_comparator_out_i,
  output logic [4:0] ctrl_lines_o,
  output logic input_ground_o,
  output logic dac_enable_o,
  output logic [mrs_pkg::DAC_W-1:0] dac_setting_o
);

  localparam int unsigned P5_CYC = P5_HALF_RAMPS * mrs_pkg::HALF_RAMP_CYC;
  localparam logic [3:0] HALF_LEN = 4'(mrs_pkg::HALF_RAMP_CYC);
  localparam logic [3:0] QUARTER_LEN = 4'(mrs_pkg::QUARTER_RAMP_CYC);
  localparam logic [7:0] COARSE_MAX = 8'(mrs_pkg::COARSE_MAX_RAMPS);
  localparam logic [7:0] FINE_MAX = 8'(mrs_pkg::FINE_MAX_RAMPS);
  localparam logic [3:0] COARSE_LAST = 4'(mrs_pkg::COARSE_SLOTS - 1);
  localparam logic [3:0] FINE_LAST = 4'(mrs_pkg::FINE_SLOTS - 1);
  localparam logic [9:0] P5_LAST = 10'(P5_CYC - 1);
  localparam logic [7:0] HALF_UNITS = 8'h02;
  localparam logic [7:0] QUARTER_UNITS = 8'h01;

  mrs_pkg::mrs_state_e state;
  mrs_pkg::mrs_state_e next_state;
  mrs_pkg::mrs_counts_s counts;
  mrs_pkg::mrs_slope_e slope;
  logic [3:0] cyc;
  logic [3:0] slot;
  logic [9:0] p5_cyc;
  logic [7:0] ramp_cnt;
  logic [7:0] neg_run;
  logic [7:0] pos_run;
  logic active;
  logic ref_cmp;
  logic neg_res;
  logic null_sel;
  logic p5_pos;
  logic first_fine_done;
  logic [15:0] calc_value;
  logic [3:0] slot_age;

  wire cmp = integrator_comparator_out_i;
  wire in_p5 = (state == mrs_pkg::ST_P5);
  wire coarse = (state == mrs_pkg::ST_P1) || (state == mrs_pkg::ST_P2);
  wire fine = (state == mrs_pkg::ST_P3) || (state == mrs_pkg::ST_P4);
  wire [3:0] slot_len = (in_p5 && p5_pos) ? QUARTER_LEN : HALF_LEN;
  wire slot_end = (cyc == slot_len - 4'h1);
  wire crossed = (cmp != ref_cmp);
  wire [3:0] last_slot = coarse ? COARSE_LAST : FINE_LAST;
  wire [7:0] max_ramps = coarse ? COARSE_MAX : FINE_MAX;
  wire brief_pos = (state == mrs_pkg::ST_P1) && !neg_res;
  wire brief_end = brief_pos && active && (cyc == QUARTER_LEN - 4'h1);
  wire phase_end = in_p5 ? (p5_cyc == P5_LAST)
                         : ((coarse || fine) && slot_end && (slot == last_slot));
  wire ramp_end = active && slot_end && !brief_pos && (coarse || fine || in_p5);
  wire [7:0] ramp_next = ramp_cnt + 8'h01;
  wire remove = ramp_end && !in_p5 && (crossed || (ramp_next == max_ramps));
  wire run_done = ramp_end && in_p5 && crossed;
  wire [7:0] unit = p5_pos ? QUARTER_UNITS : HALF_UNITS;

  // The first thousandth set measures the residual, so only later runs feed the trim
  wire keep_neg = !(run_done && !first_fine_done);
  wire trim_ok = (neg_run != 8'h00);

  // Phase order of the rundown
  always_comb begin
    next_state = state;
    case (state)
      mrs_pkg::ST_IDLE: if (start_i) next_state = mrs_pkg::ST_PREP;
      mrs_pkg::ST_PREP: next_state = mrs_pkg::ST_P1;
      mrs_pkg::ST_P1: if (phase_end) next_state = mrs_pkg::ST_P2;
      mrs_pkg::ST_P2: if (phase_end) next_state = mrs_pkg::ST_P3;
      mrs_pkg::ST_P3: if (phase_end) next_state = mrs_pkg::ST_P4;
      mrs_pkg::ST_P4: if (phase_end) next_state = mrs_pkg::ST_P5;
      mrs_pkg::ST_P5: if (phase_end) next_state = mrs_pkg::ST_DONE;
      mrs_pkg::ST_DONE: next_state = mrs_pkg::ST_IDLE;
      default: next_state = mrs_pkg::ST_IDLE;
    endcase
  end

  // Slope selection: the set current while active, else the next null
  always_comb begin
    slope = null_sel ? mrs_pkg::SL_NULL_NEG : mrs_pkg::SL_NULL_POS;
    case (state)
      mrs_pkg::ST_P1: if (active) slope = mrs_pkg::SL_NEG_COARSE;
      mrs_pkg::ST_P2: if (active) slope = mrs_pkg::SL_POS_COARSE;
      mrs_pkg::ST_P3: if (active) slope = mrs_pkg::SL_NEG_TENTH;
      mrs_pkg::ST_P4: if (active) slope = mrs_pkg::SL_POS_HUNDREDTH;
      mrs_pkg::ST_P5: begin
        slope = p5_pos ? mrs_pkg::SL_POS_THOUSANDTH : mrs_pkg::SL_NEG_THOUSANDTH;
      end
      default: slope = null_sel ? mrs_pkg::SL_NULL_NEG : mrs_pkg::SL_NULL_POS;
    endcase
  end

  // Result arithmetic
  mrs_digit_calc u_calc (
    .counts_i(counts),
    .value_o(calc_value)
  );

  // State and slot timing
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= mrs_pkg::ST_IDLE;
      cyc <= 4'h0;
      slot <= 4'h0;
      p5_cyc <= 10'h000;
    end else begin
      state <= next_state;
      if (phase_end || state == mrs_pkg::ST_PREP) begin
        cyc <= 4'h0;
        slot <= 4'h0;
        p5_cyc <= 10'h000;
      end else if (slot_end || run_done) begin
        cyc <= 4'h0;
        slot <= slot + 4'h1;
        p5_cyc <= p5_cyc + 10'h001;
      end else begin
        cyc <= cyc + 4'h1;
        p5_cyc <= p5_cyc + 10'h001;
      end
    end
  end

  // Current activity, crossing reference and polarity
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active <= 1'b0;
      ref_cmp <= 1'b0;
      neg_res <= 1'b0;
      p5_pos <= 1'b0;
      null_sel <= 1'b0;
    end else if (state == mrs_pkg::ST_PREP) begin
      neg_res <= !cmp;
      ref_cmp <= cmp;
      active <= 1'b1;
      p5_pos <= 1'b0;
    end else if (phase_end) begin
      active <= (next_state != mrs_pkg::ST_DONE);
      ref_cmp <= cmp;
      p5_pos <= 1'b0;
    end else if (remove || brief_end) begin
      active <= 1'b0;
      null_sel <= !null_sel;
    end else if (run_done) begin
      p5_pos <= !p5_pos;
      ref_cmp <= cmp;
    end
  end

  // Ramp counting per set
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ramp_cnt <= 8'h00;
      counts <= '0;
      first_fine_done <= 1'b0;
    end else if (state == mrs_pkg::ST_PREP) begin
      ramp_cnt <= 8'h00;
      counts <= '0;
      first_fine_done <= 1'b0;
    end else if (phase_end) begin
      ramp_cnt <= 8'h00;
      if (in_p5 && !first_fine_done) counts.n_neg_thousandth <= ramp_cnt;
    end else if (ramp_end && !(in_p5 && first_fine_done)) begin
      ramp_cnt <= ramp_next;
      if (remove && state == mrs_pkg::ST_P1) counts.n_neg_coarse <= ramp_next[1:0];
      if (remove && state == mrs_pkg::ST_P2) counts.n_pos_coarse <= ramp_next[1:0];
      if (remove && state == mrs_pkg::ST_P3) counts.n_neg_tenth <= ramp_next[2:0];
      if (remove && state == mrs_pkg::ST_P4) counts.n_pos_hundredth <= ramp_next[2:0];
      if (run_done) begin
        counts.n_neg_thousandth <= ramp_next;
        first_fine_done <= 1'b1;
      end
    end
  end

  // Offset DAC enable and trim from fine run lengths
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dac_enable_o <= 1'b0;
      dac_setting_o <= mrs_pkg::DAC_RESET;
      neg_run <= 8'h00;
      pos_run <= 8'h00;
    end else begin
      if (state == mrs_pkg::ST_PREP) dac_enable_o <= 1'b0;
      else if (state == mrs_pkg::ST_P3 && phase_end) dac_enable_o <= 1'b1;
      if (!in_p5 || phase_end) begin
        neg_run <= 8'h00;
        pos_run <= 8'h00;
      end else if (ramp_end && !p5_pos) begin
        neg_run <= keep_neg ? neg_run + unit : 8'h00;
        pos_run <= run_done ? 8'h00 : pos_run;
      end else if (ramp_end && p5_pos) begin
        pos_run <= pos_run + unit;
        if (run_done) begin
          pos_run <= 8'h00;
          neg_run <= 8'h00;
          if (trim_ok && pos_run + unit > neg_run && dac_setting_o != '0)
            dac_setting_o <= dac_setting_o - 1'b1;
          else if (trim_ok && pos_run + unit < neg_run && dac_setting_o != '1)
            dac_setting_o <= dac_setting_o + 1'b1;
        end
      end
    end
  end

  // Registered outputs toward controller and hybrid
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_lines_o <= mrs_pkg::SLOPE_CODE[mrs_pkg::SL_NULL_POS];
      input_ground_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      result_o <= '0;
    end else begin
      ctrl_lines_o <= mrs_pkg::SLOPE_CODE[slope];
      busy_o <= (next_state != mrs_pkg::ST_IDLE);
      done_o <= (state == mrs_pkg::ST_DONE);
      if (state == mrs_pkg::ST_IDLE && start_i) input_ground_o <= 1'b1;
      else if (state == mrs_pkg::ST_DONE) input_ground_o <= 1'b0;
      if (state == mrs_pkg::ST_DONE) begin
        result_o.neg_residual <= neg_res;
        result_o.counts <= counts;
        result_o.value <= calc_value;
      end
    end
  end

  // Cycles spent in the current slot, checked against the half-ramp length
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slot_age <= 4'h0;
    end else if (slot_end || phase_end || state == mrs_pkg::ST_PREP) begin
      slot_age <= 4'h0;
    end else if (slot_age != 4'hF) begin
      slot_age <= slot_age + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_prep;
    state == mrs_pkg::ST_PREP;
  endsequence

  sequence s_half_slot;
    ##9 slot_end;
  endsequence

  a_polarity_sample: assert property (s_prep |=> neg_res == !$past(cmp))
    else $error("residual polarity not taken from comparator");
  a_phase_order: assert property (state == mrs_pkg::ST_P3 ##1 state != mrs_pkg::ST_P3
      |-> state == mrs_pkg::ST_P4)
    else $error("phase three not followed by phase four");
  a_half_ramp_len: assert property ((coarse || fine) && cyc == 4'h0 |-> s_half_slot)
    else $error("half-ramp slot not ten cycles");
  a_slot_length: assert property ((coarse || fine) && slot_end |-> slot_age == HALF_LEN - 4'h1)
    else $error("half-ramp slot ended early");
  a_coarse_max: assert property (coarse |-> ramp_cnt <= COARSE_MAX)
    else $error("coarse set exceeded three ramps");
  a_fine_max: assert property (fine |-> ramp_cnt <= FINE_MAX)
    else $error("fine set exceeded seven ramps");
  a_removal_time: assert property (remove && !phase_end |=> !active [*1])
    else $error("current not removed after crossing");
  a_brief_coarse: assert property (brief_pos && slot != 4'h0 |-> !active)
    else $error("positive residual coarse current not brief");
  a_quarter_ramp: assert property (in_p5 && p5_pos |-> cyc < QUARTER_LEN)
    else $error("thousandth positive ramp longer than quarter-ramp");
  a_alternate: assert property (run_done && !phase_end |=> p5_pos != $past(p5_pos))
    else $error("thousandth currents did not alternate");
  a_dac_first: assert property (state == mrs_pkg::ST_P4 |-> dac_enable_o)
    else $error("offset DAC not enabled before hundredth set");
  a_ground_hold: assert property (busy_o |-> input_ground_o)
    else $error("input not grounded during rundown");
  a_null_toggle: assert property (remove && !phase_end |=> null_sel != $past(null_sel))
    else $error("null configuration did not alternate");

endmodule

// ### hw/mrs_pkg.sv
package mrs_pkg;

  // Ramp lengths in controller clock cycles
  localparam int unsigned HALF_RAMP_CYC = 10;
  localparam int unsigned QUARTER_RAMP_CYC = 5;

  // Largest ramp count per set in the bounded phases
  localparam int unsigned COARSE_MAX_RAMPS = 3;
  localparam int unsigned FINE_MAX_RAMPS = 7;

  // Slots per bounded phase: the ramps plus one closing null slot
  localparam int unsigned COARSE_SLOTS = COARSE_MAX_RAMPS + 1;
  localparam int unsigned FINE_SLOTS = FINE_MAX_RAMPS + 1;

  // Default length of the last phase in half-ramps
  localparam int unsigned P5_HALF_RAMPS = 16;

  // Weights of each set relative to the thousandth current
  localparam int unsigned W_COARSE = 1000;
  localparam int unsigned W_TENTH = 100;
  localparam int unsigned W_HUNDREDTH = 10;
  localparam int unsigned W_THOUSANDTH = 1;

  // DAC setting width and its mid-scale reset value
  localparam int unsigned DAC_W = 6;
  localparam logic [DAC_W-1:0] DAC_RESET = 6'h20;

  // Slope selections driven to the hybrid
  typedef enum logic [2:0] {
    SL_NEG_COARSE = 3'h0,
    SL_POS_COARSE = 3'h1,
    SL_NEG_TENTH = 3'h2,
    SL_POS_HUNDREDTH = 3'h3,
    SL_NEG_THOUSANDTH = 3'h4,
    SL_POS_THOUSANDTH = 3'h5,
    SL_NULL_NEG = 3'h6,
    SL_NULL_POS = 3'h7
  } mrs_slope_e;

  // Five-line code of each slope selection, indexed by mrs_slope_e
  localparam logic [7:0][4:0] SLOPE_CODE = {
    5'h06, 5'h05, 5'h03, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01
  };

  // Sequencer states, Gray coded along the rundown path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PREP = 3'h1,
    ST_P1 = 3'h3,
    ST_P2 = 3'h2,
    ST_P3 = 3'h6,
    ST_P4 = 3'h7,
    ST_P5 = 3'h5,
    ST_DONE = 3'h4
  } mrs_state_e;

  // Ramp counts of the five sets
  typedef struct packed {
    logic [1:0] n_neg_coarse;
    logic [1:0] n_pos_coarse;
    logic [2:0] n_neg_tenth;
    logic [2:0] n_pos_hundredth;
    logic [7:0] n_neg_thousandth;
  } mrs_counts_s;

  // Rundown result handed to the reading logic
  typedef struct packed {
    logic neg_residual;
    mrs_counts_s counts;
    logic [15:0] value;
  } mrs_result_s;

endpackage

// ### hw/mrs_digit_calc.sv
// Weighted sum of the set counts in thousandth-current units
module mrs_digit_calc (
  // Counts in
  input wire mrs_pkg::mrs_counts_s counts_i,
  // Signed residual, two's complement
  output logic [15:0] value_o
);

  logic [15:0] t_neg_coarse;
  logic [15:0] t_pos_coarse;
  logic [15:0] t_neg_tenth;
  logic [15:0] t_pos_hundredth;
  logic [15:0] t_neg_thousandth;

  // Each set's charge scaled by its current weight
  assign t_neg_coarse = 16'(mrs_pkg::W_COARSE) * 16'(counts_i.n_neg_coarse);
  assign t_pos_coarse = 16'(mrs_pkg::W_COARSE) * 16'(counts_i.n_pos_coarse);
  assign t_neg_tenth = 16'(mrs_pkg::W_TENTH) * 16'(counts_i.n_neg_tenth);
  assign t_pos_hundredth = 16'(mrs_pkg::W_HUNDREDTH) * 16'(counts_i.n_pos_hundredth);
  assign t_neg_thousandth = 16'(mrs_pkg::W_THOUSANDTH) * 16'(counts_i.n_neg_thousandth);

  // Negative sets add, positive sets subtract
  assign value_o = t_neg_coarse - t_pos_coarse + t_neg_tenth - t_pos_hundredth
                   + t_neg_thousandth;

endmodule

// ### test/mrs_hybrid_model.sv
// Behavioural converter hybrid: slope switches, integrator and comparator
module mrs_hybrid_model (
  // Clock
  input wire logic ref_clk_i,
  // Controller side
  input wire logic [4:0] ctrl_lines_i,
  input wire logic load_i,
  input wire logic signed [31:0] preset_i,
  // Comparator back to the controller
  output logic cmp_o
);
  timeunit 1ns;
  timeprecision 1ns;

  int v = 0;
  int rate;

  // Decode the five-line code; negative currents give a rising output
  always_comb begin
    case (ctrl_lines_i)
      5'h01: rate = 1000;
      5'h02: rate = -1000;
      5'h04: rate = 100;
      5'h08: rate = -10;
      5'h10: rate = 1;
      5'h03: rate = -1;
      default: rate = 0;
    endcase
  end

  // Switches follow the latched code each clock; comparator latched per clock
  initial cmp_o = 1'b0;
  always @(posedge ref_clk_i) begin
    v <= load_i ? preset_i : v + rate;
    cmp_o <= (v > 0);
  end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the rundown sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start_i = 1'b0;
  logic load = 1'b0;
  logic signed [31:0] preset = '0;
  logic busy_o, done_o, cmp, input_ground_o, dac_enable_o;
  logic [4:0] ctrl_lines_o;
  logic [mrs_pkg::DAC_W-1:0] dac_setting_o;
  mrs_pkg::mrs_result_s result_o;
  int bad_count = 0;
  int compares = 0;
  int code_cyc [32];
  int run = 0;
  int first10 = -1;
  int ref_span = 0;
  logic [4:0] prev = 5'h06;
  logic [4:0] last_null = 5'h06;
  logic [4:0] seq [$];

  mrs_sequencer dut_u (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
    .busy_o(busy_o), .done_o(done_o), .result_o(result_o),
    .integrator_comparator_out_i(cmp), .ctrl_lines_o(ctrl_lines_o),
    .input_ground_o(input_ground_o), .dac_enable_o(dac_enable_o),
    .dac_setting_o(dac_setting_o)
  );

  mrs_hybrid_model hyb_u (
    .ref_clk_i(ref_clk_i), .ctrl_lines_i(ctrl_lines_o), .load_i(load),
    .preset_i(preset), .cmp_o(cmp)
  );

  // Clock at 100 ns
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic bit is_null(input logic [4:0] c);
    return c == 5'h05 || c == 5'h06;
  endfunction

  function automatic bit is_fine(input logic [4:0] c);
    return c == 5'h10 || c == 5'h03;
  endfunction

  // Watch the slope lines during each rundown
  always @(negedge ref_clk_i) begin
    if (!sys_rst_i && busy_o) begin
      check(input_ground_o, 1'b1);
      check(ctrl_lines_o inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03, 5'h05, 5'h06}, 1);
      if (ctrl_lines_o == 5'h08) check(dac_enable_o, 1'b1);
      code_cyc[ctrl_lines_o]++;
      if (ctrl_lines_o != prev && !is_null(prev) && prev != 5'h01 &&
          (is_fine(ctrl_lines_o) || !is_fine(prev)))
        check(run % (prev == 5'h03 ? 5 : 10), 0);
      if (prev == 5'h10 && ctrl_lines_o == 5'h03 && first10 < 0) first10 = run;
      if (is_null(ctrl_lines_o) && !is_null(prev)) check(ctrl_lines_o != last_null, 1);
      if (!is_null(ctrl_lines_o) && ctrl_lines_o != prev) seq.push_back(ctrl_lines_o);
    end
    if (is_null(ctrl_lines_o)) last_null = ctrl_lines_o;
    run = (ctrl_lines_o == prev) ? run + 1 : 1;
    prev = ctrl_lines_o;
  end

  // Preset the integrator, start once, retry start while busy, wait for done
  task automatic rundown(input int res, output int n);
    load = 1'b1;
    preset = res;
    @(negedge ref_clk_i);
    load = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    foreach (code_cyc[i]) code_cyc[i] = 0;
    seq.delete();
    first10 = -1;
    start_i = 1'b1;
    @(negedge ref_clk_i);
    start_i = 1'b0;
    n = 1;
    while (done_o !== 1'b1 && n < 1000) begin
      @(negedge ref_clk_i);
      n++;
      start_i = (n == 60);
    end
    check(done_o, 1'b1);
    n = n - 1;
  endtask

  task automatic verify(input bit neg, input int n1, n2, n3, n4, n5);
    int v;
    v = 1000 * n1 - 1000 * n2 + 100 * n3 - 10 * n4 + n5;
    check(result_o.neg_residual, neg);
    check(result_o.counts, {n1[1:0], n2[1:0], n3[2:0], n4[2:0], n5[7:0]});
    check(result_o.value, v[15:0]);
    check(code_cyc[1], neg ? n1 * 10 : 5);
    check(code_cyc[2], n2 * 10);
    check(code_cyc[4], n3 * 10);
    check(code_cyc[8], n4 * 10);
    check(first10, n5 * 10);
    check(dac_enable_o, 1'b1);
    check(dac_setting_o, mrs_pkg::DAC_RESET);
    check(seq.size() >= 6, 1'b1);
    foreach (seq[k]) check(seq[k], k < 4 ? 5'h01 << k : (k % 2 ? 5'h03 : 5'h10));
  endtask

  task automatic check_idle;
    check({busy_o, done_o, input_ground_o, dac_enable_o}, 4'h0);
    check(ctrl_lines_o, 5'h06);
    check(dac_setting_o, mrs_pkg::DAC_RESET);
  endtask

  task automatic test_negative;
    int n;
    int span;
    // Preparation and done cycles around the five fixed-length phases
    span = 2 + (2 * mrs_pkg::COARSE_SLOTS + 2 * mrs_pkg::FINE_SLOTS
           + mrs_pkg::P5_HALF_RAMPS) * mrs_pkg::HALF_RAMP_CYC;
    rundown(-25345, n);
    check(n, span);
    ref_span = n;
    verify(1'b1, 3, 1, 6, 7, 5);
    $display("test negative residual done");
  endtask

  task automatic test_positive;
    int n;
    rundown(9655, n);
    check(n, ref_span);
    verify(1'b0, 0, 2, 6, 7, 5);
    $display("test positive residual done");
  endtask

  // Reset in mid-run returns every output that check_idle reads to idle
  task automatic test_reset;
    start_i = 1'b1;
    @(negedge ref_clk_i);
    start_i = 1'b0;
    repeat (100) @(negedge ref_clk_i);
    sys_rst_i = 1'b1;
    #1;
    check_idle();
    repeat (2) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    @(negedge ref_clk_i);
    check_idle();
    $display("test mid-run reset done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    check_idle();
    test_negative();
    test_reset();
    test_positive();
    tally_and_finish();
  end

  // Watchdog well beyond three rundowns
  initial begin
    #500us;
    bad_count++;
    tally_and_finish();
  end
endmodule
